// *** verilog/pyr_pkg.sv ***
// Purpose: shared constants and types for the pyro single-wire readout
// Assumes: core clock of 40 MHz (25 ns period)
// Notes:   times are kept in their own unit, cycles derive from them
`default_nettype none
package pyr_pkg;
    localparam longint CLK_PS      = 25000;      // core clock period in ps
    localparam int     TMR_W       = 20;         // width of link timer
    localparam int     ADC_W       = 14;         // sample width
    localparam int     FRAME_W     = 28;         // bits per frame
    localparam int     BIT_CNT_W   = 5;          // frame bit index width
    localparam int     FIFO_DEPTH  = 16;         // buffered frames
    // times, as printed
    localparam longint HOLD_NS     = 110000;     // start_pulse_hold_time
    localparam longint ABORT_NS    = 145000;     // cancel low time
    localparam longint IDLE_NS     = 14600000;   // sample_period limit
    localparam longint PERIOD_NS   = 16000000;   // announce period
    localparam longint SHORT_NS    = 16000000;   // input discharge
    localparam longint STROBE_NS   = 200;        // strobe_high_phase min
    localparam longint SETTLE_NS   = 2000;       // bit_settle_time
    localparam longint PULSE_NS    = 2000;       // announce drive time
    // least times round up
    localparam longint HOLD_L   = (HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam longint ABORT_L  = (ABORT_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam longint IDLE_L   = (IDLE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam longint PERIOD_L = (PERIOD_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam longint SHORT_L  = (SHORT_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam longint STROBE_L = (STROBE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam longint SETTLE_L = (SETTLE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam longint PULSE_L  = (PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam logic [TMR_W-1:0] HOLD_CYC   = TMR_W'(HOLD_L);
    localparam logic [TMR_W-1:0] ABORT_CYC  = TMR_W'(ABORT_L);
    localparam logic [TMR_W-1:0] IDLE_CYC   = TMR_W'(IDLE_L);
    localparam logic [TMR_W-1:0] PERIOD_CYC = TMR_W'(PERIOD_L);
    localparam logic [TMR_W-1:0] SHORT_CYC  = TMR_W'(SHORT_L);
    localparam logic [TMR_W-1:0] STROBE_CYC = TMR_W'(STROBE_L);
    localparam logic [TMR_W-1:0] SETTLE_CYC = TMR_W'(SETTLE_L);
    localparam logic [TMR_W-1:0] PULSE_CYC  = TMR_W'(PULSE_L);
    // adc range and filter
    localparam logic [ADC_W-1:0] RANGE_LO   = 14'h01FF;   // 511
    localparam logic [ADC_W-1:0] RANGE_HI   = 14'h3E01;   // 2^14 - 511
    localparam int               LPF_SHIFT  = 4;          // iir weight 1/16
    localparam logic [ADC_W-1:0] FILT_INIT  = 14'h2000;   // mid scale
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = 5'h00;
    localparam logic [BIT_CNT_W-1:0] TOP_BIT  = 5'h1B;    // bit 27

    typedef struct packed {
        logic [ADC_W-1:0] pyro;   // bits 27:14
        logic [ADC_W-1:0] temp;   // bits 13:0
    } pyr_frame_s;

    typedef enum logic [2:0] {
        ST_IDLE, ST_HOST_HIGH, ST_ANNOUNCE, ST_ANN_WAIT, ST_BIT_WAIT,
        ST_BIT_OUT
    } pyr_link_e;
endpackage : pyr_pkg
`default_nettype wire

// *** verilog/pyr_one_wire_readout.sv ***
// Purpose: sensor end of the single-wire readout, with sample buffer
// Assumes: line input asynchronous; pad resolves out/oe to the wire
// Notes:   bit 0 is driven low for a settle window, then released
`timescale 1ns/10ps
`default_nettype none

// simple circular buffer, one word in and out per cycle
module pyr_fifo
    import pyr_pkg::*;
#(
    parameter int WIDTH = FRAME_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic             core_clk,  // core clock
    input  wire logic             reset_n,   // sync reset, active low
    input  wire logic [WIDTH-1:0] inData,    // write word
    input  wire logic             inValid,   // write request
    output logic                  inReady,   // room available
    output logic      [WIDTH-1:0] outData,   // head word
    output logic                  outValid,  // head word present
    input  wire logic             outReady   // head consumed
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr;
    logic [AW:0]      rdPtr;
    wire              doWrite = inValid & inReady;
    wire              doRead  = outValid & outReady;

    // full when pointers differ only in the wrap bit
    assign inReady  = !((wrPtr[AW] != rdPtr[AW]) &&
                        (wrPtr[AW-1:0] == rdPtr[AW-1:0]));
    assign outValid = (wrPtr != rdPtr);
    assign outData  = mem[rdPtr[AW-1:0]];

    // storage has no reset, only pointers do
    always_ff @(posedge core_clk) begin
        if (doWrite) begin
            mem[wrPtr[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            wrPtr <= wrPtr + (AW+1)'(doWrite);
            rdPtr <= rdPtr + (AW+1)'(doRead);
        end
    end
endmodule : pyr_fifo

module pyr_one_wire_readout
    import pyr_pkg::*;
#(
    parameter logic [TMR_W-1:0] HOLD_CYCLES   = HOLD_CYC,    // 110 us
    parameter logic [TMR_W-1:0] ABORT_CYCLES  = ABORT_CYC,   // 145 us
    parameter logic [TMR_W-1:0] IDLE_CYCLES   = IDLE_CYC,    // 14.6 ms
    parameter logic [TMR_W-1:0] PERIOD_CYCLES = PERIOD_CYC,  // 16 ms
    parameter logic [TMR_W-1:0] SHORT_CYCLES  = SHORT_CYC    // 16 ms
) (
    input  wire logic        core_clk,     // 40 MHz clock
    input  wire logic        reset_n,      // sync reset, active low
    input  wire pyr_frame_s  sampleIn,     // raw pyro and temp words
    input  wire logic        sampleValid,  // sample offered
    output logic             sampleReady,  // sample accepted
    input  wire logic        lineIn,       // wire level from pad
    output logic             lineOut,      // level to drive
    output logic             lineOe_n,     // low while driving
    output logic             shortInput,   // discharge sensor input
    output logic             frameBusy     // frame in progress
);
    pyr_link_e          state;
    logic [TMR_W-1:0]   timer;
    logic [TMR_W-1:0]   shortTimer;
    logic [2:0]         lineSync;
    logic               lineLevel;
    logic [ADC_W-1:0]   filt;
    logic [FRAME_W-1:0] shiftReg;
    logic [FRAME_W-1:0] lastFrame;
    logic [BIT_CNT_W-1:0] bitIdx;
    pyr_frame_s         fifoIn;
    logic [FRAME_W-1:0] fifoOut;
    logic               fifoValid;

    // line edges only when the last two stages agree
    wire lineRise  = lineSync[1] & lineSync[2] & ~lineLevel;
    wire lineFall  = ~lineSync[1] & ~lineSync[2] & lineLevel;

    // iir low-pass toward the new raw pyro value
    wire signed [ADC_W+1:0] filtDiff = $signed({2'b00, sampleIn.pyro}) -
                                       $signed({2'b00, filt});
    wire signed [ADC_W+1:0] filtStep = filtDiff >>> LPF_SHIFT;
    wire [ADC_W-1:0] next_filt = ADC_W'($signed({2'b00, filt}) + filtStep);
    wire sampleTake = sampleValid & sampleReady;
    wire outOfRange = sampleTake &&
                      ((next_filt < RANGE_LO) || (next_filt > RANGE_HI));

    // frame start: pop a fresh word, else resend the last one
    wire frameStart = (state == ST_HOST_HIGH && lineFall &&
                       timer >= HOLD_CYCLES) ||
                      (state == ST_ANN_WAIT && lineFall);
    wire fifoPop    = frameStart & fifoValid;
    wire [FRAME_W-1:0] startWord = fifoValid ? fifoOut : lastFrame;
    wire bitDone    = (state == ST_BIT_OUT) && (timer == SETTLE_CYC);
    wire lowAbort   = (state == ST_BIT_WAIT) && !lineLevel &&
                      (timer >= ABORT_CYCLES - 1'b1);
    // edges restart the timer only where they mean something, so the
    // bit window runs from the strobe and our own drive cannot stretch it
    wire timerClear = bitDone || lowAbort ||
                      (state == ST_IDLE &&
                       (lineRise || timer >= IDLE_CYCLES - 1'b1)) ||
                      (state == ST_HOST_HIGH && lineFall) ||
                      (state == ST_ANN_WAIT &&
                       (lineFall || timer >= PERIOD_CYCLES - 1'b1)) ||
                      (state == ST_BIT_WAIT && (lineRise || lineFall));

    assign fifoIn = '{pyro: next_filt, temp: sampleIn.temp};

    pyr_fifo #(.WIDTH(FRAME_W), .DEPTH(FIFO_DEPTH)) sampleBuf (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .inData   (fifoIn),
        .inValid  (sampleValid),
        .inReady  (sampleReady),
        .outData  (fifoOut),
        .outValid (fifoValid),
        .outReady (fifoPop)
    );

    // pad drive: high during announce, low for a 0 bit after strobe
    wire driveHigh = (state == ST_ANNOUNCE);
    wire driveLow  = (state == ST_BIT_OUT) && (timer >= STROBE_CYC) &&
                     !shiftReg[FRAME_W-1];
    assign frameBusy = (state == ST_BIT_WAIT) || (state == ST_BIT_OUT);
    assign shortInput = (shortTimer != '0);

    // pad flops: a decode glitch must never reach the shared wire
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            lineOut  <= 1'b0;
            lineOe_n <= 1'b1;
        end else begin
            lineOut  <= driveHigh;
            lineOe_n <= !(driveHigh | driveLow);
        end
    end

    // three-stage line synchroniser with agreement filter
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            lineSync  <= '0;
            lineLevel <= 1'b0;
        end else begin
            lineSync  <= {lineSync[1:0], lineIn};
            lineLevel <= (lineSync[1] == lineSync[2]) ? lineSync[2]
                                                       : lineLevel;
        end
    end

    // filter state and discharge timer
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            filt       <= FILT_INIT;
            shortTimer <= '0;
        end else begin
            if (sampleTake) filt <= next_filt;
            if (outOfRange) shortTimer <= SHORT_CYCLES;
            else if (shortTimer != '0) shortTimer <= shortTimer - 1'b1;
        end
    end

    // shared timer: idle, hold, pulse, period, abort and bit windows
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            timer <= '0;
        end else if (timerClear) begin
            timer <= '0;
        end else if (timer != '1) begin
            timer <= timer + 1'b1;
        end
    end

    // link sequencer
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (lineRise) state <= ST_HOST_HIGH;
                    else if (timer >= IDLE_CYCLES - 1'b1)
                        state <= ST_ANNOUNCE;
                end
                ST_HOST_HIGH: begin
                    if (frameStart) state <= ST_BIT_WAIT;
                    else if (lineFall) state <= ST_IDLE;       // too short
                end
                ST_ANNOUNCE: begin
                    if (timer == PULSE_CYC) state <= ST_ANN_WAIT;
                end
                ST_ANN_WAIT: begin
                    if (frameStart) state <= ST_BIT_WAIT;
                    else if (timer >= PERIOD_CYCLES - 1'b1)
                        state <= ST_ANNOUNCE;
                end
                ST_BIT_WAIT: begin
                    if (lowAbort) state <= ST_IDLE;
                    else if (lineRise) state <= ST_BIT_OUT;
                end
                ST_BIT_OUT: begin
                    if (bitDone) state <= (bitIdx == LAST_BIT) ? ST_IDLE
                                                               : ST_BIT_WAIT;
                end
            endcase
        end
    end

    // frame shifter, msb first
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            shiftReg  <= '0;
            lastFrame <= '0;
            bitIdx    <= '0;
        end else if (frameStart) begin
            shiftReg  <= startWord;
            lastFrame <= startWord;
            bitIdx    <= TOP_BIT;
        end else if (bitDone) begin
            shiftReg  <= {shiftReg[FRAME_W-2:0], 1'b0};
            bitIdx    <= bitIdx - 1'b1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    pyro_word_a: assert property (fifoPop |=> shiftReg[27:14] ==
        $past(fifoOut[27:14])) else $error("pyro field misplaced");
    temp_word_a: assert property (fifoPop |=> shiftReg[13:0] ==
        $past(fifoOut[13:0])) else $error("temp field misplaced");
    filt_dir_a: assert property (sampleTake && sampleIn.pyro > filt |=>
        filt >= $past(filt)) else $error("filter moves wrong way");
    short_start_a: assert property ($rose(shortInput) |->
        $past(outOfRange) ##1 shortInput [*8])
        else $error("discharge bad start");
    start_rise_a: assert property (state == ST_IDLE ##1
        state == ST_HOST_HIGH |-> $past(lineRise))
        else $error("start without rise");
    idle_announce_a: assert property (state == ST_IDLE ##1
        state == ST_ANNOUNCE |-> $past(timer) == IDLE_CYCLES - 1'b1)
        else $error("announce at wrong time");
    period_ann_a: assert property (state == ST_ANN_WAIT ##1
        state == ST_ANNOUNCE |-> $past(timer) == PERIOD_CYCLES - 1'b1)
        else $error("announce period wrong");
    zero_drive_a: assert property (!lineOe_n && !lineOut |->
        $past(state == ST_BIT_OUT && !shiftReg[FRAME_W-1]))
        else $error("low drive not a zero bit");
    abort_low_a: assert property (state == ST_BIT_WAIT ##1
        state == ST_IDLE |-> $past(timer) >= ABORT_CYCLES - 1'b1)
        else $error("abort too early");

    host_frame_c: cover property (state == ST_HOST_HIGH ##1
        state == ST_BIT_WAIT);
    sensor_frame_c: cover property (state == ST_ANN_WAIT ##1
        state == ST_BIT_WAIT);
    frame_end_c: cover property (bitDone && bitIdx == LAST_BIT);
    abort_c: cover property (lowAbort);
endmodule : pyr_one_wire_readout
`default_nettype wire

// *** verif/pyr_host_model.sv ***
// Purpose: host side of the single-wire readout, behavioural
// Assumes: wire level resolved by the bench from both enables
// Notes:   bit timing is fixed, about 2.25 us per bit
`timescale 1ns/10ps
`default_nettype none
module pyr_host_model
    import pyr_pkg::*;
(
    input  wire logic core_clk,  // core clock
    input  wire logic lineIn,    // resolved wire level
    output logic      hostOut,   // level the host drives
    output logic      hostOe_n   // low while the host drives
);
    logic syncA;  // first stage
    logic syncB;  // settled wire level

    // host starts out holding the wire low
    initial begin
        hostOut = 1'b0;
        hostOe_n = 1'b0;
    end

    // two flops before any decision on the wire
    always @(posedge core_clk) begin
        syncA <= lineIn;
        syncB <= syncA;
    end

    // one level, or release, for n cycles from the next falling edge
    task automatic drive(input logic lvl, input logic oe_n, input int n);
        @(negedge core_clk);
        hostOut = lvl;
        hostOe_n = oe_n;
        repeat (n - 1) @(negedge core_clk);
    endtask : drive

    // high for hi cycles, then low starts the frame
    task automatic forced_start(input int hi);
        drive(1'b1, 1'b0, hi);
        drive(1'b0, 1'b0, 10);
    endtask : forced_start

    // n strobes, msb first; 28 bits take about 63 us
    task automatic read_bits(input int n, output logic [27:0] bits);
        bits = '0;
        for (int i = 27; i > 27 - n; i--) begin
            drive(1'b1, 1'b0, 10);
            drive(1'b1, 1'b1, 40);
            bits[i] = syncB;
            drive(1'b0, 1'b0, 40);
        end
    endtask : read_bits
endmodule : pyr_host_model
`default_nettype wire

// *** verif/pyr_one_wire_readout_tb.sv ***
// Purpose: self-checking bench for the pyro single-wire readout
// Assumes: shortened link times, host model on the far side
// Notes:   a released wire keeps its charge, there is no pull
`timescale 1ns/10ps
`default_nettype none
module pyr_one_wire_readout_tb;
    import pyr_pkg::*;
    localparam logic [TMR_W-1:0] HOLD_T  = 20'h00014;  // 20 cycles
    localparam logic [TMR_W-1:0] ABORT_T = 20'h0001E;  // 30 cycles
    localparam logic [TMR_W-1:0] IDLE_T  = 20'h0012C;  // 300 cycles
    localparam logic [TMR_W-1:0] PER_T   = 20'h00190;  // 400 cycles
    localparam logic [TMR_W-1:0] SHORT_T = 20'h00032;  // 50 cycles
    logic        core_clk, reset_n;       // clock and reset
    pyr_frame_s  sampleIn;                // raw sample
    logic        sampleValid, sampleReady;  // sample handshake
    logic        lineOut, lineOe_n, shortInput, frameBusy;  // outputs
    logic        hostOut, hostOe_n, wireLvl;  // host side and wire
    logic [27:0] bits;                    // frame read by the host
    logic [27:0] expQ[$];                 // expected frames
    int          numErrors, numChecks, cyc, tRel, t1, t2, w;
    logic [13:0] prevPyro = '0, prevExp = '0;  // last pyro words

    pyr_one_wire_readout #(.HOLD_CYCLES(HOLD_T), .ABORT_CYCLES(ABORT_T),
        .IDLE_CYCLES(IDLE_T), .PERIOD_CYCLES(PER_T),
        .SHORT_CYCLES(SHORT_T)) pyr_one_wire_readout_inst (
        .core_clk(core_clk), .reset_n(reset_n), .sampleIn(sampleIn),
        .sampleValid(sampleValid), .sampleReady(sampleReady),
        .lineIn(wireLvl), .lineOut(lineOut), .lineOe_n(lineOe_n),
        .shortInput(shortInput), .frameBusy(frameBusy));
    pyr_host_model pyr_host_model_inst (.core_clk(core_clk),
        .lineIn(wireLvl), .hostOut(hostOut), .hostOe_n(hostOe_n));

    // wire level; contention shows as unknown, released keeps charge
    always @* begin
        if (lineOe_n === 1'b0 && hostOe_n === 1'b0) begin
            wireLvl = (lineOut === hostOut) ? lineOut : 1'bx;
        end else if (lineOe_n === 1'b0) begin
            wireLvl = lineOut;
        end else if (hostOe_n === 1'b0) begin
            wireLvl = hostOut;
        end
    end

    // clock, cycle count and watchdog
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) cyc <= cyc + 1;
    initial begin
        repeat (95000) @(posedge core_clk);
        numErrors++;
        $display("FAIL %0t watchdog expired", $time);
        tallyAndFinish();
    end

    task automatic check(input logic [27:0] seen, input logic [27:0] exp);
        numChecks++;
        if (seen !== exp) begin
            numErrors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // forced read of a whole frame against the oldest expected word
    // the offset-free step between frames is what a band-pass host keeps
    task automatic read_check;
        logic [27:0] exp;
        pyr_host_model_inst.forced_start(30);
        pyr_host_model_inst.read_bits(28, bits);
        pyr_host_model_inst.drive(1'b0, 1'b1, 1);
        exp = expQ.pop_front();
        check(bits, exp);
        check(28'(bits[27:14] - prevPyro), 28'(exp[27:14] - prevExp));
        prevPyro = bits[27:14];
        prevExp = exp[27:14];
    endtask : read_check

    // too short a start pulse must not open a frame
    task automatic scen_short_hold;
        pyr_host_model_inst.forced_start(int'(HOLD_T) - 8);
        repeat (20) @(negedge core_clk);
        check(28'(frameBusy), 28'h0);
    endtask : scen_short_hold

    // fill until refused, drain by reads, walk the filter out of range
    task automatic scen_stream;
        int f;
        int k;
        bit crossed;
        f = int'(FILT_INIT);
        crossed = 1'b0;
        for (k = 0; !crossed; k++) begin
            @(negedge core_clk);
            sampleIn.pyro = (k == 0) ? 14'h2100 : 14'h0000;
            sampleIn.temp = k[13:0];
            sampleValid = 1'b1;
            if (sampleReady !== 1'b1) begin
                repeat (3) @(negedge core_clk);
                check(28'(sampleReady), 28'h0);
                sampleValid = 1'b0;
                read_check();
                sampleValid = 1'b1;
            end
            f = f + ((int'(sampleIn.pyro) - f) >>> 4);
            crossed = (f < 511);
            expQ.push_back({f[13:0], sampleIn.temp});
        end
        @(negedge core_clk);
        sampleValid = 1'b0;
        for (w = 0; w < 3 && shortInput !== 1'b1; w++) @(negedge core_clk);
        for (w = 0; w < 200 && shortInput === 1'b1; w++) @(negedge core_clk);
        check(28'(w), 28'(SHORT_T));
    endtask : scen_stream

    // start of the next device drive-high pulse, w ends as its width
    task automatic wait_pulse(output int t);
        for (w = 0; w < 1000 && !(lineOe_n === 1'b0 && lineOut === 1'b1);
             w++) @(negedge core_clk);
        t = cyc;
        for (w = 0; w < 200 && lineOe_n === 1'b0; w++) @(negedge core_clk);
    endtask : wait_pulse

    // host waits released, skips one announce, answers the next
    task automatic scen_announce;
        pyr_host_model_inst.drive(1'b0, 1'b1, 1);
        tRel = cyc;
        wait_pulse(t1);
        check(28'(w), 28'h51);
        check(28'(t1 - tRel <= int'(IDLE_T)), 28'h1);
        wait_pulse(t2);
        check(28'(t2 - t1), 28'(PER_T));
        pyr_host_model_inst.drive(1'b0, 1'b0, 10);
        pyr_host_model_inst.read_bits(28, bits);
        pyr_host_model_inst.drive(1'b0, 1'b1, 1);
        check(bits, expQ.pop_front());
    endtask : scen_announce

    // long low after three bits cancels the frame
    task automatic scen_abort;
        pyr_host_model_inst.forced_start(30);
        pyr_host_model_inst.read_bits(3, bits);
        check(28'(frameBusy), 28'h1);
        check(28'(bits[27:25]), 28'(expQ[0][27:25]));
        pyr_host_model_inst.drive(1'b0, 1'b0, int'(ABORT_T) + 40);
        pyr_host_model_inst.drive(1'b0, 1'b1, 10);
        check(28'(frameBusy), 28'h0);
    endtask : scen_abort

    task automatic tallyAndFinish;
        $display("checks %0d errors %0d", numChecks, numErrors);
        if (numErrors == 0 && numChecks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tallyAndFinish

    // two cycles of reset initialise every flop except the buffer storage, synchroniser included; filt to mid scale, lineOe_n high
    initial begin
        reset_n = 1'b0;
        sampleValid = 1'b0;
        sampleIn = '0;
        repeat (2) @(negedge core_clk);
        check(28'({lineOe_n, shortInput, frameBusy, sampleReady}), 28'h9);
        reset_n = 1'b1;
        scen_short_hold();
        scen_stream();
        scen_announce();
        scen_abort();
        tallyAndFinish();
    end
endmodule : pyr_one_wire_readout_tb
`default_nettype wire
